// >>> hdl/ufb_pkg.sv
// shared constants, types and helpers of the uart flow control and baud generator
`default_nettype none
package ufb_pkg;
	// register word indexes; byte address is four times the index
	localparam logic [5:0] IDX_CTRL     = 6'h00;
	localparam logic [5:0] IDX_PRESCALE = 6'h01;
	localparam logic [5:0] IDX_CHARS    = 6'h02;
	localparam logic [5:0] IDX_DIVISOR  = 6'h03;
	localparam logic [5:0] IDX_SAMPLE   = 6'h04;
	localparam logic [5:0] IDX_STATUS   = 6'h05;
	localparam logic [5:0] IDX_TRIG     = 6'h06;
	// control word field positions
	localparam int CTL_RXM     = 0;
	localparam int CTL_TXM     = 2;
	localparam int CTL_ENH     = 4;
	localparam int CTL_SPECIAL = 5;
	localparam int CTL_ARTS    = 6;
	localparam int CTL_ACTS    = 7;
	localparam int CTL_SW_RTS  = 8;
	localparam int CTL_XON_ANY = 9;
	localparam int CTL_PRESEL  = 10;
	localparam int CTL_SW_DTR  = 11;
	localparam int CTL_ACR     = 12;
	localparam int CTL_IE5     = 16;
	// status word field positions
	localparam int ST_TXDIS  = 0;
	localparam int ST_REMDIS = 1;
	localparam int ST_INBAND = 4;
	// prescaler fields
	localparam int CPR_M_LO = 3;
	localparam int CPR_N_W  = 3;
	// reset values
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [7:0]  PRESCALE_RST = 8'h20;
	localparam logic [3:0]  SAMPLE_RST   = 4'h0;
	localparam logic [15:0] DIVISOR_RST  = 16'h0001;
	localparam logic [7:0]  UPPER_RST    = 8'h60;
	localparam logic [7:0]  LOWER_RST    = 8'h20;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef struct packed {
		logic [7:0] data;
		logic       bad;
	} ufb_char_s;

	typedef enum logic [0:0] {
		INS_IDLE = 1'b0,
		INS_SEND = 1'b1
	} ufb_ins_e;

	function automatic logic [4:0] ufb_samples(input logic [3:0] code);
		ufb_samples = (code < 4'h4) ? 5'h10 : {1'b0, code};
	endfunction : ufb_samples

	function automatic logic [31:0] ufb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			ufb_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : ufb_merge
endpackage : ufb_pkg
`default_nettype wire

// >>> hdl/ufb_prescale.sv
// fractional m+n/8 prescaler producing one enable pulse per prescaled clock
`timescale 1ns/10ps
`default_nettype none
module ufb_prescale (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       bypass,
	input  wire logic [7:0] prescale,
	output var  logic       tick
);
	import ufb_pkg::*;
	logic [8:0] acc;
	logic [8:0] next_acc;
	logic       next_tick;
	logic [8:0] step;
	logic [8:0] sum;

	// prescale accumulator: average rate is clock*8/(8m+n)
	always_comb begin
		step      = {1'b0, prescale};
		sum       = acc + 9'h008;
		next_acc  = acc;
		next_tick = 1'b0;
		if (bypass || prescale[7:CPR_M_LO] == 5'h00) begin
			next_acc  = 9'h000;
			next_tick = 1'b1;
		end else if (sum >= step) begin
			next_acc  = sum - step;
			next_tick = 1'b1;
		end else begin
			next_acc  = sum;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc  <= 9'h000;
			tick <= 1'b0;
		end else begin
			acc  <= next_acc;
			tick <= next_tick;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bypass_rate_a: assert property (bypass |=> tick)
		else $error("bypassed prescaler missed a tick");
endmodule : ufb_prescale
`default_nettype wire

// >>> hdl/ufb_baud_div.sv
// divisor and sampling clock counters giving sample and bit ticks
`timescale 1ns/10ps
`default_nettype none
module ufb_baud_div (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        pre_tick,
	input  wire logic [15:0] divisor,
	input  wire logic [3:0]  sample_code,
	output var  logic        sample_tick,
	output var  logic        bit_tick
);
	import ufb_pkg::*;
	logic [15:0] div_cnt;
	logic [4:0]  smp_cnt;
	logic [15:0] next_div_cnt;
	logic [4:0]  next_smp_cnt;
	logic        next_sample;
	logic        next_bit;

	always_comb begin
		next_div_cnt = div_cnt;
		next_smp_cnt = smp_cnt;
		next_sample  = 1'b0;
		next_bit     = 1'b0;
		if (pre_tick) begin
			// a zero divisor is served as one rather than stalling
			if (div_cnt + 16'h0001 >= divisor) begin
				next_div_cnt = 16'h0000;
				next_sample  = 1'b1;
				if (smp_cnt + 5'h01 >= ufb_samples(sample_code)) begin
					next_smp_cnt = 5'h00;
					next_bit     = 1'b1;
				end else begin
					next_smp_cnt = smp_cnt + 5'h01;
				end
			end else begin
				next_div_cnt = div_cnt + 16'h0001;
			end
		end
		// a sample count shrunk below the counter restarts it at once, not a slow tick later
		if (smp_cnt >= ufb_samples(sample_code)) begin
			next_smp_cnt = 5'h00;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt     <= 16'h0000;
			smp_cnt     <= 5'h00;
			sample_tick <= 1'b0;
			bit_tick    <= 1'b0;
		end else begin
			div_cnt     <= next_div_cnt;
			smp_cnt     <= next_smp_cnt;
			sample_tick <= next_sample;
			bit_tick    <= next_bit;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// bit tick only with a sample tick
	bit_on_sample_a: assert property (bit_tick |-> sample_tick)
		else $error("bit tick without sample tick");
	sample_range_a: assert property (smp_cnt < ufb_samples(sample_code) || $changed(sample_code))
		else $error("sample counter out of range");
endmodule : ufb_baud_div
`default_nettype wire

// >>> hdl/ufb_flow_baud.sv
// uart in-band and modem-line flow control with baud generation and axi4-lite registers
// What this block does
// - a received stop character halts transmit after current character, sets status bits
// - stop condition raises level 5 interrupt only when its enable is set
// - after stop, a resume character re-enables transmit and clears status bits
// - matched stop/resume characters are not stored, except stop two with special detect
// - character errors do not prevent stop/resume matching
// - resume-on-any: any character resumes transmit and is also stored
// - fill level is checked whenever the transmitter is idle, inserting flow characters
// - remote-disabled clear and level above upper: send stop, set remote-disabled
// - remote-disabled set and level below lower: send resume, clear remote-disabled
// - disabling transmit flow control with stop outstanding sends a resume
// - legacy mode: one bit enables both auto rts/cts; enhanced: separate bits
// - auto cts: withheld permission stops transmit after current character
// - auto rts: inactive at upper level, active again below lower level
// - auto rts is anded with software rts bit
// - dtr/dsr flow control like rts/cts, enabled by two control bits in any mode
// - baud divisor is 16 bits, low plus 256 times high
// - bit rate is clock over samples times divisor times prescaler
// - samples per bit programmable from 4 to 16
// - prescaler divides by m plus n/8
// - prescaler select clear bypasses prescaler
// - reset bypasses prescaler and sets sample code to zero, meaning 16
// - sample codes 0 to 3 give 16, codes 4 to 15 give 4 to 15
// - prescaler select writes only take effect in enhanced mode
// - prescaler register resets to divide by four
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ufb_flow_baud (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	input  wire logic              rx_valid,
	input  wire ufb_pkg::ufb_char_s rx_char,
	output var  logic              rx_store_valid,
	output var  ufb_pkg::ufb_char_s rx_store,
	input  wire logic [7:0]        receive_fill_level,
	input  wire logic              tx_idle,
	output var  logic              tx_enable,
	output var  logic              ins_valid,
	output var  logic [7:0]        ins_char,
	input  wire logic              ins_ack,
	input  wire logic              cts_n,
	input  wire logic              dsr_n,
	output var  logic              rts_n,
	output var  logic              dtr_n,
	output var  logic              level5_int,
	output var  logic              sample_tick,
	output var  logic              bit_tick
);
	import ufb_pkg::*;

	logic [31:0] ctrl, next_ctrl;
	logic [7:0]  clock_prescale, next_prescale;
	logic [31:0] chars, next_chars;
	logic [15:0] divisor, next_divisor;
	logic [3:0]  sample_clock_count, next_sample;
	logic [7:0]  upper, next_upper, lower, next_lower;
	logic        tx_dis, next_tx_dis, inband, next_inband;
	logic        aw_held, next_aw_held, w_held, next_w_held;
	logic [5:0]  aw_idx, next_aw_idx;
	logic        aw_ok, next_aw_ok;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata, rd_word;
	logic        rd_ok, do_wr;
	logic        next_store_valid;
	ufb_char_s   next_store;
	ufb_ins_e    ins_state, next_ins_state;
	logic        remote_dis, next_remote_dis, pair_one, next_pair_one;
	logic        next_ins_valid;
	logic [7:0]  next_ins_char;
	logic        hold_full, next_hold_full;
	logic        next_rts_n, next_dtr_n, next_tx_enable, next_level5;
	logic        enh, xon_any, special, stop1, stop2, res1, res2, stop_hit, res_hit;
	logic [1:0]  rxm, txm;
	logic        tx_on, auto_rts, auto_cts, pre_tick;
	logic [7:0]  stop_one, stop_two, res_one, res_two;

	assign stop_one = chars[7:0];
	assign stop_two = chars[15:8];
	assign res_one  = chars[23:16];
	assign res_two  = chars[31:24];
	assign enh      = ctrl[CTL_ENH];
	// in-band flow modes, resume-on-any and special detect drop out entirely when the mode bit is clear
	assign rxm      = enh ? ctrl[CTL_RXM +: 2] : 2'b00;
	assign txm      = enh ? ctrl[CTL_TXM +: 2] : 2'b00;
	assign xon_any  = enh && ctrl[CTL_XON_ANY];
	assign special  = enh && ctrl[CTL_SPECIAL];
	assign tx_on    = (txm == 2'b01) || (txm == 2'b10);
	assign stop1    = rxm[1] && rx_char.data == stop_one;
	assign stop2    = rxm[0] && rx_char.data == stop_two;
	assign res1     = rxm[1] && rx_char.data == res_one;
	assign res2     = rxm[0] && rx_char.data == res_two;
	assign stop_hit = stop1 || stop2;
	assign res_hit  = res1 || res2;
	assign auto_rts = enh ? ctrl[CTL_ARTS] : ctrl[CTL_XON_ANY];
	assign auto_cts = enh ? ctrl[CTL_ACTS] : ctrl[CTL_XON_ANY];
	assign do_wr    = aw_held && w_held && !bvalid;

	// axi4-lite write channel; address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_aw_idx  = aw_idx;
		next_aw_ok   = aw_ok;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_idx  = awaddr[7:2];
			next_aw_ok   = awaddr[1:0] == 2'b00 && awaddr[7:2] <= IDX_TRIG;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (do_wr) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = aw_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_idx  <= 6'h00;
			aw_ok   <= 1'b0;
			w_held  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			awready <= 1'b1;
			wready  <= 1'b1;
		end else begin
			aw_held <= next_aw_held;
			aw_idx  <= next_aw_idx;
			aw_ok   <= next_aw_ok;
			w_held  <= next_w_held;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			awready <= !next_aw_held;
			wready  <= !next_w_held;
		end
	end

	// read mux; reserved bits read as zero, except unused control word bits, which read back as written
	always_comb begin
		rd_ok   = araddr[1:0] == 2'b00;
		rd_word = 32'h0000_0000;
		case (araddr[7:2])
			IDX_CTRL:     rd_word = ctrl;
			IDX_PRESCALE: rd_word = {24'h00_0000, clock_prescale};
			IDX_CHARS:    rd_word = chars;
			IDX_DIVISOR:  rd_word = {16'h0000, divisor};
			IDX_SAMPLE:   rd_word = {28'h000_0000, sample_clock_count};
			IDX_STATUS:   rd_word = {27'h000_0000, inband, 2'b00, remote_dis, tx_dis};
			IDX_TRIG:     rd_word = {16'h0000, lower, upper};
			default:      rd_ok = 1'b0;
		endcase
		next_arready = arready;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rdata   = rd_ok ? rd_word : 32'h0000_0000;
			next_rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			next_arready = 1'b1;
			next_rvalid  = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// configuration registers and receive-side flow control
	always_comb begin
		next_ctrl        = ctrl;
		next_prescale    = clock_prescale;
		next_chars       = chars;
		next_divisor     = divisor;
		next_sample      = sample_clock_count;
		next_upper       = upper;
		next_lower       = lower;
		next_tx_dis      = tx_dis;
		next_inband      = inband;
		next_store_valid = 1'b0;
		next_store       = rx_char;
		if (do_wr && aw_ok) begin
			case (aw_idx)
				IDX_CTRL: begin
					next_ctrl = ufb_merge(ctrl, w_data, w_strb);
					// prescaler select held outside enhanced mode
					if (!enh) begin
						next_ctrl[CTL_PRESEL] = ctrl[CTL_PRESEL];
					end
				end
				IDX_PRESCALE: next_prescale = w_strb[0] ? w_data[7:0] : clock_prescale;
				IDX_CHARS:    next_chars = ufb_merge(chars, w_data, w_strb);
				IDX_DIVISOR: begin
					next_divisor[7:0]  = w_strb[0] ? w_data[7:0] : divisor[7:0];
					next_divisor[15:8] = w_strb[1] ? w_data[15:8] : divisor[15:8];
				end
				IDX_SAMPLE:   next_sample = w_strb[0] ? w_data[3:0] : sample_clock_count;
				IDX_TRIG: begin
					next_upper = w_strb[0] ? w_data[7:0] : upper;
					next_lower = w_strb[1] ? w_data[15:8] : lower;
				end
				IDX_STATUS: begin
					// writing zero re-enables a transmitter held by a stop character
					if (w_strb[0] && !w_data[ST_TXDIS]) begin
						next_tx_dis = 1'b0;
						next_inband = 1'b0;
					end
				end
				default: next_ctrl = ctrl;
			endcase
		end
		if (rx_valid) begin
			next_store_valid = 1'b1;
			if (tx_dis && xon_any) begin
				next_tx_dis = 1'b0;
				next_inband = 1'b0;
			end else if (tx_dis && res_hit) begin
				next_tx_dis      = 1'b0;
				next_inband      = 1'b0;
				next_store_valid = 1'b0;
			end else if (stop_hit) begin
				// stop match halts transmit; set wins over a software clear
				next_tx_dis      = 1'b1;
				next_inband      = 1'b1;
				// stop two kept when special detect is on
				next_store_valid = special && rx_char.data == stop_two;
			end else if (res_hit) begin
				next_store_valid = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl               <= CTRL_RST;
			clock_prescale     <= PRESCALE_RST;
			chars              <= 32'h0000_0000;
			divisor            <= DIVISOR_RST;
			sample_clock_count <= SAMPLE_RST;
			upper              <= UPPER_RST;
			lower              <= LOWER_RST;
			tx_dis             <= 1'b0;
			inband             <= 1'b0;
			rx_store_valid     <= 1'b0;
			rx_store           <= '0;
		end else begin
			ctrl               <= next_ctrl;
			clock_prescale     <= next_prescale;
			chars              <= next_chars;
			divisor            <= next_divisor;
			sample_clock_count <= next_sample;
			upper              <= next_upper;
			lower              <= next_lower;
			tx_dis             <= next_tx_dis;
			inband             <= next_inband;
			rx_store_valid     <= next_store_valid;
			rx_store           <= next_store;
		end
	end

	// transmit-side insertion of flow characters
	always_comb begin
		next_ins_state  = ins_state;
		next_remote_dis = remote_dis;
		next_pair_one   = pair_one;
		next_ins_valid  = ins_valid;
		next_ins_char   = ins_char;
		case (ins_state)
			INS_IDLE: begin
				if (tx_idle) begin
					if (tx_on && !remote_dis && receive_fill_level > upper) begin
						next_remote_dis = 1'b1;
						next_pair_one   = txm[1];
						next_ins_char   = txm[1] ? stop_one : stop_two;
						next_ins_valid  = 1'b1;
						next_ins_state  = INS_SEND;
					end else if (remote_dis && (!tx_on || receive_fill_level < lower)) begin
						// send resume of the pair used for the stop
						next_remote_dis = 1'b0;
						next_ins_char   = pair_one ? res_one : res_two;
						next_ins_valid  = 1'b1;
						next_ins_state  = INS_SEND;
					end
				end
			end
			INS_SEND: begin
				if (ins_ack) begin
					next_ins_valid = 1'b0;
					next_ins_state = INS_IDLE;
				end
			end
			default: next_ins_state = INS_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ins_state  <= INS_IDLE;
			remote_dis <= 1'b0;
			pair_one   <= 1'b0;
			ins_valid  <= 1'b0;
			ins_char   <= 8'h00;
		end else begin
			ins_state  <= next_ins_state;
			remote_dis <= next_remote_dis;
			pair_one   <= next_pair_one;
			ins_valid  <= next_ins_valid;
			ins_char   <= next_ins_char;
		end
	end

	// modem lines and transmit gating
	always_comb begin
		// hysteresis between the two trigger levels
		next_hold_full = hold_full ? !(receive_fill_level < lower) : (receive_fill_level >= upper);
		next_rts_n = !(ctrl[CTL_SW_RTS] && !(auto_rts && hold_full));
		// dtr/dsr pair, enabled in any mode
		next_dtr_n = !(ctrl[CTL_SW_DTR] && !(ctrl[CTL_ACR + 1] && hold_full));
		// transmitter checks this only between characters
		next_tx_enable = !tx_dis && !(auto_cts && cts_n) && !(ctrl[CTL_ACR] && dsr_n);
		// level 5 gated by its enable
		next_level5 = inband && enh && ctrl[CTL_IE5];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_full  <= 1'b0;
			rts_n      <= 1'b1;
			dtr_n      <= 1'b1;
			tx_enable  <= 1'b1;
			level5_int <= 1'b0;
		end else begin
			hold_full  <= next_hold_full;
			rts_n      <= next_rts_n;
			dtr_n      <= next_dtr_n;
			tx_enable  <= next_tx_enable;
			level5_int <= next_level5;
		end
	end

	ufb_prescale u_prescale (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.bypass   (!ctrl[CTL_PRESEL]),
		.prescale (clock_prescale),
		.tick     (pre_tick)
	);

	ufb_baud_div u_baud (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.pre_tick    (pre_tick),
		.divisor     (divisor),
		.sample_code (sample_clock_count),
		.sample_tick (sample_tick),
		.bit_tick    (bit_tick)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence stop_seen;
		rx_valid && !tx_dis && stop_hit && !xon_any;
	endsequence
	sequence resume_seen;
		rx_valid && tx_dis && res_hit && !xon_any;
	endsequence
	stop_halts_a: assert property (stop_seen |=> tx_dis && inband ##1 !tx_enable)
		else $error("stop character did not halt transmit");
	level_five_a: assert property (inband && enh && ctrl[CTL_IE5] |=> level5_int)
		else $error("level 5 interrupt missing");
	resume_clears_a: assert property (resume_seen |=> !tx_dis && !inband)
		else $error("resume character did not clear");
	stop_not_kept_a: assert property (stop_seen and !special |=> !rx_store_valid)
		else $error("stop character stored");
	bad_still_matches_a: assert property (stop_seen and rx_char.bad |=> tx_dis)
		else $error("errored stop character ignored");
	any_resumes_a: assert property (rx_valid && tx_dis && xon_any |=> !tx_dis && rx_store_valid)
		else $error("resume on any character failed");
	send_stop_a: assert property (ins_state == INS_IDLE && tx_idle && tx_on && !remote_dis
		&& receive_fill_level > upper |=> ins_valid && remote_dis)
		else $error("stop not inserted above upper level");
	off_resumes_a: assert property (ins_state == INS_IDLE && tx_idle && remote_dis && !tx_on
		|=> ins_valid && !remote_dis && ins_char == (pair_one ? res_one : res_two))
		else $error("resume not sent when flow control turned off");
	cts_blocks_a: assert property (auto_cts && cts_n |=> !tx_enable)
		else $error("cts did not block transmit");
	rts_override_a: assert property (!ctrl[CTL_SW_RTS] |=> rts_n)
		else $error("software rts did not force inactive");
endmodule : ufb_flow_baud
`default_nettype wire

// >>> verif/ufb_remote.sv
// far-side serial device: acks inserted flow characters, drives modem permission lines
`timescale 1ns/10ps
`default_nettype none
module ufb_remote (
	input  wire logic aclk,
	input  wire logic slow,
	input  wire logic busy,
	input  wire logic ins_valid,
	output var  logic ins_ack,
	output var  logic cts_n,
	output var  logic dsr_n
);
	int wait_cnt = 0;
	initial ins_ack = 1'b0;
	// a busy remote withholds permission on both lines
	assign cts_n = busy;
	assign dsr_n = busy;
	// slow mode lets the request stand for several cycles
	always @(posedge aclk) begin
		ins_ack <= ins_valid && !ins_ack && wait_cnt >= (slow ? 6 : 0);
		wait_cnt <= (ins_valid && !ins_ack) ? wait_cnt + 1 : 0;
	end
endmodule : ufb_remote
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the flow control and baud generator
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ufb_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic rx_valid = 0, tx_idle = 0, slow = 0, busy = 0;
	logic [7:0] awaddr = 0, araddr = 0, receive_fill_level = 0, ins_char;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, rx_store_valid, tx_enable, ins_valid, ins_ack;
	logic cts_n, dsr_n, rts_n, dtr_n, level5_int, sample_tick, bit_tick;
	ufb_char_s rx_char = '0, rx_store;
	int bad_count = 0, comparisons = 0, stores = 0, p, s;
	ufb_flow_baud u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rx_valid(rx_valid), .rx_char(rx_char), .rx_store_valid(rx_store_valid),
		.rx_store(rx_store), .receive_fill_level(receive_fill_level), .tx_idle(tx_idle), .tx_enable(tx_enable),
		.ins_valid(ins_valid), .ins_char(ins_char), .ins_ack(ins_ack), .cts_n(cts_n), .dsr_n(dsr_n),
		.rts_n(rts_n), .dtr_n(dtr_n), .level5_int(level5_int), .sample_tick(sample_tick), .bit_tick(bit_tick));
	ufb_remote u_remote (.aclk(aclk), .slow(slow), .busy(busy), .ins_valid(ins_valid), .ins_ack(ins_ack),
		.cts_n(cts_n), .dsr_n(dsr_n));
	initial forever #12.5 aclk = ~aclk;
	always @(posedge aclk) if (rx_store_valid === 1'b1) stores++;
	task automatic wr(input logic [5:0] i, input logic [31:0] v);
		awaddr <= {i, 2'b00};
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
		// one spare edge so a following call never re-raises what was just dropped
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [5:0] i);
		araddr <= {i, 2'b00};
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 0;
		@(posedge aclk);
	endtask : rd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("compares %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic rx(input logic [7:0] c);
		rx_char <= {c, 1'b1};
		rx_valid <= 1;
		@(posedge aclk);
		rx_valid <= 0;
		repeat (3) @(posedge aclk);
	endtask : rx
	task automatic ins(input logic [7:0] c);
		do @(posedge aclk); while (ins_valid !== 1'b1);
		chk(ins_char, c);
		do @(posedge aclk); while (ins_valid === 1'b1);
		repeat (3) @(posedge aclk);
	endtask : ins
	task automatic per;
		do @(posedge aclk); while (bit_tick !== 1'b1);
		p = 0;
		s = 0;
		do begin
			@(posedge aclk);
			p++;
			if (sample_tick === 1'b1) s++;
		end while (bit_tick !== 1'b1);
	endtask : per
	task automatic t_reset;
		rd(IDX_PRESCALE);
		chk(d, 32'h20);
		rd(IDX_SAMPLE);
		chk(d, 32'h0);
		rd(6'h3f);
		chk(rresp, RESP_SLVERR);
		wr(6'h3f, 32'h0);
		chk(bresp, RESP_SLVERR);
		$display("reset test done");
	endtask : t_reset
	task automatic t_rx_flow;
		wr(IDX_CHARS, 32'h9111_9313);
		wr(IDX_CTRL, 32'h0001_0113);
		rx(8'h13);
		chk(tx_enable, 0);
		chk(level5_int, 1);
		rd(IDX_STATUS);
		chk(d & 32'h13, 32'h11);
		rx(8'h91);
		chk(tx_enable, 1);
		chk(stores, 0);
		wr(IDX_CTRL, 32'h0001_0333);
		rx(8'h93);
		chk(tx_enable, 0);
		chk(stores, 1);
		rx(8'h55);
		chk(tx_enable, 1);
		chk(stores, 2);
		chk(rx_store, {8'h55, 1'b1});
		$display("receive flow test done");
	endtask : t_rx_flow
	task automatic t_tx_flow;
		wr(IDX_CTRL, 32'h158);
		slow <= 1;
		receive_fill_level <= 8'h61;
		tx_idle <= 1;
		ins(8'h13);
		chk(rts_n, 1);
		rd(IDX_STATUS);
		chk(d & 32'h2, 32'h2);
		receive_fill_level <= 8'h1f;
		ins(8'h11);
		chk(rts_n, 0);
		wr(IDX_CTRL, 32'h58);
		repeat (3) @(posedge aclk);
		chk(rts_n, 1);
		receive_fill_level <= 8'h61;
		ins(8'h13);
		wr(IDX_CTRL, 32'h90);
		ins(8'h11);
		busy <= 1;
		repeat (4) @(posedge aclk);
		chk(tx_enable, 0);
		wr(IDX_CTRL, 32'h3800);
		repeat (3) @(posedge aclk);
		chk(dtr_n, 1);
		chk(tx_enable, 0);
		receive_fill_level <= 8'h1f;
		busy <= 0;
		repeat (4) @(posedge aclk);
		chk(dtr_n, 0);
		chk(tx_enable, 1);
		$display("transmit flow test done");
	endtask : t_tx_flow
	task automatic t_baud;
		wr(IDX_SAMPLE, 32'h4);
		wr(IDX_DIVISOR, 32'h2);
		wr(IDX_CTRL, 32'h0);
		per;
		chk(p, 8);
		chk(s, 4);
		wr(IDX_CTRL, 32'h400);
		rd(IDX_CTRL);
		chk(d & 32'h400, 0);
		wr(IDX_CTRL, 32'h10);
		wr(IDX_CTRL, 32'h410);
		per;
		chk(p, 32);
		wr(IDX_SAMPLE, 32'h3);
		per;
		chk(p, 128);
		chk(s, 16);
		$display("baud test done");
	endtask : t_baud
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_rx_flow;
		t_tx_flow;
		t_baud;
		test_done;
	end
	initial begin
		#2000000;
		bad_count++;
		test_done;
	end
endmodule : testbench
`default_nettype wire
